// ---- usb_pin_pkg.sv ----
// Shared constants, encodings and timing for the pin function block.
package usb_pin_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int STROBE_NS = 32;
  localparam int STROBE_CYCLES =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOF_STATES = 8;
  localparam int RESET_HOLD_PERIODS = 64;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ADDR_HI_LSB = 8;

  localparam logic [7:0] ADDR_HI_RST = 8'hff;
  localparam logic [7:0] LOW_BUS_RST = 8'hff;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  typedef enum logic [1:0] {
    KIND_FETCH = 2'b00,
    KIND_READ = 2'b01,
    KIND_WRITE = 2'b10
  } cycle_kind_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_STROBE = 2'b10,
    BUS_DONE = 2'b11
  } bus_state_t;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_PDOWN = 2'b10
  } power_mode_t;

endpackage

// ---- pin_sync_if.sv ----
// Raw pin level in, filtered level out, between a synchroniser and its user.
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ---- pin_sync.sv ----
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pin levels
  pin_sync_if.sync port
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] clean;

  wire agree = (stage2 == stage3);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      clean <= RST_VAL;
    end else begin
      stage1 <= port.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      if (agree) begin
        clean <= stage3;
      end
    end
  end

  assign port.clean = clean;

endmodule

// ---- usb_ctrl_pin_functions.sv ----
// Pin level logic: memory strobes, indicators, frame pulse and reset pin.
// Behaviour
// [RL1] Data LED output active low, idles high.
// [RL2] Isolated power control active low, idles high.
// [RL3] Modem reset active low, holds modem side.
// [RL4] Upper address byte driven on dedicated port.
// [RL5] Program fetch strobe only for code reads.
// [RL6] Data read strobe only for data reads.
// [RL7] Write strobe asserted for external memory writes.
// [RL8] Reset pin held 64 periods resets chip.
// [RL9] Reset pin high forces pins to reset.
// [RL10] Reset pin exits idle or powerdown mode.
// [RL11] Start of frame pulse lasts eight states.
// [RL12] Rate select strap tied high for full speed.
// [RL13] Address latch strobe opens every bus cycle.
// [RL14] Low address and data share one bus.
// [RL15] Active low outputs stay high after reset.
`timescale 1ns/1ps
module usb_ctrl_pin_functions
  import usb_pin_pkg::*;
#(
  parameter int STROBE_LEN = STROBE_CYCLES,
  parameter int SOF_LEN = SOF_STATES,
  parameter int HOLD_LEN = RESET_HOLD_PERIODS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Reset pin and rate strap
  input wire logic rst_pin,
  input wire logic pll_rate_select,
  output logic full_speed_sel,
  // Low power control
  input wire logic idle_req,
  input wire logic powerdown_req,
  output logic [1:0] power_mode,
  // Firmware controls for the indicator outputs
  input wire logic led_on,
  input wire logic iso_power_on,
  input wire logic modem_side_reset_on,
  // Indicator and modem side outputs
  output logic data_led_n,
  output logic isolated_power_ctl_n,
  output logic modem_side_reset_n,
  // Frame timer
  input wire logic frame_locked,
  input wire logic sof_detect,
  output logic start_of_frame_n,
  // External memory cycle requests
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_done,
  output logic [DATA_W-1:0] rsp_rdata,
  // External memory pins
  output logic [DATA_W-1:0] upper_addr_port,
  output logic addr_latch_strobe,
  input wire logic [DATA_W-1:0] addr_data_low_in,
  output logic [DATA_W-1:0] addr_data_low_out,
  output logic addr_data_low_oe,
  output logic program_fetch_strobe_n,
  output logic data_read_strobe_n,
  output logic write_strobe_n
);

  pin_sync_if #(.W(1)) rst_sync_if();
  pin_sync_if #(.W(1)) pll_sync_if();
  pin_sync_if #(.W(DATA_W)) low_sync_if();

  assign rst_sync_if.raw = rst_pin;
  assign pll_sync_if.raw = pll_rate_select;
  assign low_sync_if.raw = addr_data_low_in;

  pin_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .port(rst_sync_if.sync)
  );

  pin_sync #(.W(1), .RST_VAL(1'b0)) u_pll_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .port(pll_sync_if.sync)
  );

  pin_sync #(.W(DATA_W), .RST_VAL(LOW_BUS_RST)) u_low_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .port(low_sync_if.sync)
  );

  bus_state_t state;
  bus_state_t next_state;
  power_mode_t mode;
  power_mode_t next_mode;
  logic [CNT_W-1:0] strobe_cnt;
  logic [CNT_W-1:0] sof_cnt;
  logic [CNT_W-1:0] hold_cnt;
  logic [1:0] cur_kind;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] cur_wdata;

  wire pin_rst = rst_sync_if.clean[0];
  wire hold_end = (hold_cnt == CNT_W'(HOLD_LEN - 1));
  wire chip_rst = pin_rst && hold_end; // [RL8]
  wire req_take = req_valid && req_ready;
  wire strobe_last = (strobe_cnt == '0);
  wire [1:0] act_kind = req_take ? req_kind : cur_kind;
  wire [ADDR_W-1:0] act_addr = req_take ? req_addr : cur_addr;
  wire [DATA_W-1:0] act_wdata = req_take ? req_wdata : cur_wdata;
  wire next_busy = (next_state != BUS_IDLE);
  wire next_addr_ph = (next_state == BUS_ADDR) && !pin_rst;
  wire next_strobe_ph = (next_state == BUS_STROBE) && !pin_rst;
  wire next_write_ph = next_strobe_ph && (act_kind == KIND_WRITE);
  wire capture = (state == BUS_STROBE) && strobe_last &&
                 (cur_kind != KIND_WRITE);
  wire sof_start = frame_locked && sof_detect && (sof_cnt == '0);

  // Bus cycle sequencing; the reset pin aborts any cycle in flight.
  always_comb begin
    next_state = state;
    case (state)
      BUS_IDLE: begin
        if (req_take) begin
          next_state = BUS_ADDR;
        end
      end
      BUS_ADDR: begin
        next_state = BUS_STROBE; // [RL13]
      end
      BUS_STROBE: begin
        if (strobe_last) begin
          next_state = BUS_DONE;
        end
      end
      BUS_DONE: begin
        next_state = BUS_IDLE;
      end
      default: begin
        next_state = BUS_IDLE;
      end
    endcase
    if (pin_rst) begin
      next_state = BUS_IDLE; // [RL9]
    end
  end

  // Low power mode entry by request, exit on the reset pin.
  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_RUN: begin
        if (powerdown_req && state == BUS_IDLE) begin
          next_mode = MODE_PDOWN;
        end else if (idle_req && state == BUS_IDLE) begin
          next_mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        next_mode = MODE_IDLE;
      end
      MODE_PDOWN: begin
        next_mode = MODE_PDOWN;
      end
      default: begin
        next_mode = MODE_RUN;
      end
    endcase
    if (pin_rst) begin
      next_mode = MODE_RUN; // [RL10]
    end
  end

  wire next_req_ready = !next_busy && (next_mode == MODE_RUN) && !pin_rst;
  wire [DATA_W-1:0] next_upper = (next_busy && !pin_rst) ?
                                 act_addr[ADDR_W-1:ADDR_HI_LSB] :
                                 ADDR_HI_RST; // [RL4]
  wire [DATA_W-1:0] next_low_out = next_addr_ph ? act_addr[DATA_W-1:0] :
                                   next_write_ph ? act_wdata :
                                   LOW_BUS_RST; // [RL14]
  wire next_low_oe = next_addr_ph || next_write_ph; // [RL14]
  wire next_fetch_n = !(next_strobe_ph && act_kind == KIND_FETCH); // [RL5]
  wire next_read_n = !(next_strobe_ph && act_kind == KIND_READ); // [RL6]
  wire next_write_n = !next_write_ph; // [RL7]
  wire [CNT_W-1:0] next_strobe_cnt = (next_state == BUS_ADDR) ?
                                     CNT_W'(STROBE_LEN - 1) :
                                     (state == BUS_STROBE && !strobe_last) ?
                                     strobe_cnt - 1'b1 : strobe_cnt;
  wire [CNT_W-1:0] next_sof_cnt = chip_rst ? '0 :
                                  sof_start ? CNT_W'(SOF_LEN) :
                                  (sof_cnt != '0) ? sof_cnt - 1'b1 :
                                  sof_cnt; // [RL11]
  wire [CNT_W-1:0] next_hold_cnt = !pin_rst ? '0 :
                                   hold_end ? hold_cnt :
                                   hold_cnt + 1'b1; // [RL8]

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= BUS_IDLE;
      mode <= MODE_RUN;
      strobe_cnt <= '0;
      sof_cnt <= '0;
      hold_cnt <= '0;
      cur_kind <= KIND_FETCH;
      cur_addr <= ADDR_RST;
      cur_wdata <= RDATA_RST;
    end else begin
      state <= next_state;
      mode <= next_mode;
      strobe_cnt <= next_strobe_cnt;
      sof_cnt <= next_sof_cnt;
      hold_cnt <= next_hold_cnt;
      cur_kind <= act_kind;
      cur_addr <= act_addr;
      cur_wdata <= act_wdata;
    end
  end

  // Pin registers; the reset pin forces every pin to its reset level.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      data_led_n <= 1'b1; // [RL15]
      isolated_power_ctl_n <= 1'b1; // [RL15]
      modem_side_reset_n <= 1'b1; // [RL15]
      start_of_frame_n <= 1'b1;
      upper_addr_port <= ADDR_HI_RST;
      addr_latch_strobe <= 1'b0;
      addr_data_low_out <= LOW_BUS_RST;
      addr_data_low_oe <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      data_read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      data_led_n <= pin_rst || !led_on; // [RL1] [RL9]
      isolated_power_ctl_n <= pin_rst || !iso_power_on; // [RL2] [RL9]
      modem_side_reset_n <= pin_rst || !modem_side_reset_on; // [RL3]
      start_of_frame_n <= pin_rst || (next_sof_cnt == '0); // [RL11]
      upper_addr_port <= next_upper;
      addr_latch_strobe <= next_addr_ph; // [RL13]
      addr_data_low_out <= next_low_out;
      addr_data_low_oe <= next_low_oe;
      program_fetch_strobe_n <= next_fetch_n;
      data_read_strobe_n <= next_read_n;
      write_strobe_n <= next_write_n;
    end
  end

  // Request answers and the strap latched by a full chip reset.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
      rsp_done <= 1'b0;
      rsp_rdata <= RDATA_RST;
      full_speed_sel <= 1'b0;
    end else begin
      req_ready <= next_req_ready;
      rsp_done <= (next_state == BUS_DONE);
      if (capture) begin
        rsp_rdata <= low_sync_if.clean;
      end
      if (chip_rst) begin
        full_speed_sel <= pll_sync_if.clean[0]; // [RL12]
      end
    end
  end

  assign power_mode = mode;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  led_follows_a: assert property ( // [RL1]
    !pin_rst |=> data_led_n == !$past(led_on))
    else $error("data led does not follow its control");

  iso_power_a: assert property ( // [RL2]
    (!pin_rst && iso_power_on) ##1 (!pin_rst && iso_power_on)
      |=> !isolated_power_ctl_n)
    else $error("isolated power control not asserted low");

  modem_reset_a: assert property ( // [RL3]
    !modem_side_reset_n |-> $past(modem_side_reset_on) && !$past(pin_rst))
    else $error("modem reset low without its control");

  upper_addr_a: assert property ( // [RL4]
    state == BUS_STROBE |-> upper_addr_port == cur_addr[ADDR_W-1:ADDR_HI_LSB])
    else $error("upper address port wrong during strobe");

  fetch_only_a: assert property ( // [RL5]
    !program_fetch_strobe_n |-> state == BUS_STROBE &&
      cur_kind == KIND_FETCH && data_read_strobe_n && write_strobe_n)
    else $error("program fetch strobe outside a code read");

  read_only_a: assert property ( // [RL6]
    !data_read_strobe_n |-> state == BUS_STROBE &&
      cur_kind == KIND_READ && !addr_data_low_oe)
    else $error("data read strobe outside a data read");

  write_data_a: assert property ( // [RL7]
    !write_strobe_n |-> addr_data_low_oe && addr_data_low_out == cur_wdata)
    else $error("write strobe without write data on bus");

  hold_time_a: assert property ( // [RL8]
    chip_rst |-> pin_rst && $past(pin_rst, 63))
    else $error("chip reset before reset pin hold time");

  pin_force_a: assert property ( // [RL9]
    pin_rst |=> data_led_n && program_fetch_strobe_n &&
      data_read_strobe_n && write_strobe_n && !addr_data_low_oe &&
      upper_addr_port == ADDR_HI_RST)
    else $error("pins not forced while reset pin high");

  mode_exit_a: assert property ( // [RL10]
    (pin_rst && mode != MODE_RUN) |=> mode == MODE_RUN)
    else $error("reset pin did not leave low power mode");

  sof_width_a: assert property ( // [RL11]
    ($fell(start_of_frame_n) && !pin_rst) |->
      (!start_of_frame_n || pin_rst) [*8] ##1 start_of_frame_n)
    else $error("start of frame pulse width wrong");

  ale_first_a: assert property ( // [RL13]
    (addr_latch_strobe && !pin_rst) |=>
      !(program_fetch_strobe_n && data_read_strobe_n && write_strobe_n))
    else $error("no strobe after address latch strobe");

  low_addr_a: assert property ( // [RL14]
    addr_latch_strobe |-> addr_data_low_oe &&
      addr_data_low_out == cur_addr[DATA_W-1:0])
    else $error("low address not on shared bus");

  reset_high_a: assert property ( // [RL15]
    $rose(rst_b) |-> data_led_n && isolated_power_ctl_n &&
      modem_side_reset_n && start_of_frame_n)
    else $error("active low outputs not high after reset");

endmodule

// ---- ext_mem_model.sv ----
// External memory partner that latches the address and answers strobes.
`timescale 1ns/1ps
module ext_mem_model (
  // Clock
  input wire logic core_clk,
  // Memory pins
  input wire logic [7:0] upper_addr_port,
  input wire logic addr_latch_strobe,
  input wire logic [7:0] bus,
  input wire logic program_fetch_strobe_n,
  input wire logic data_read_strobe_n,
  input wire logic write_strobe_n,
  output logic [7:0] drive
);
  logic [15:0] addr;
  logic [7:0] mem [int];
  always @(posedge core_clk) begin
    if (addr_latch_strobe) addr <= {upper_addr_port, bus};
    if (!write_strobe_n) mem[addr] = bus;
  end
  // A released bus floats to the pullup level.
  always @* begin
    if (!program_fetch_strobe_n || !data_read_strobe_n) begin
      if (mem.exists(addr)) drive = mem[addr];
      else drive = addr[7:0] ^ addr[15:8] ^ 8'h5a;
    end else drive = 8'hff;
  end
endmodule

// ---- usb_ctrl_pin_functions_tb.sv ----
// Self-checking bench for the pin function block.
`timescale 1ns/1ps
module usb_ctrl_pin_functions_tb;
  import usb_pin_pkg::*;
  localparam int SLEN = 8;
  logic core_clk = 0, rst_b = 0, rst_pin = 0;
  logic pll_rate_select = 1;
  logic idle_req = 0, powerdown_req = 0, frame_locked = 0, sof_detect = 0;
  logic led_on = 0, iso_power_on = 0, modem_side_reset_on = 0;
  logic req_valid = 0;
  logic [1:0] req_kind = 0;
  logic [15:0] req_addr = 0;
  logic [7:0] req_wdata = 0;
  logic full_speed_sel, data_led_n, isolated_power_ctl_n, modem_side_reset_n;
  logic [1:0] power_mode;
  logic start_of_frame_n, req_ready, rsp_done, addr_latch_strobe;
  logic addr_data_low_oe, program_fetch_strobe_n, data_read_strobe_n;
  logic write_strobe_n;
  logic [7:0] rsp_rdata, upper_addr_port, addr_data_low_out, drive, bus;
  logic [7:0] exp_mem [int];
  int bad_count = 0, check_count = 0, seed = 74;
  assign bus = (addr_data_low_oe ? addr_data_low_out : 8'hff) & drive;
  always #2 core_clk = ~core_clk;
  usb_ctrl_pin_functions #(.STROBE_LEN(SLEN)) u_dut (
    .core_clk, .rst_b, .rst_pin, .pll_rate_select, .full_speed_sel,
    .idle_req, .powerdown_req, .power_mode, .led_on, .iso_power_on,
    .modem_side_reset_on, .data_led_n, .isolated_power_ctl_n,
    .modem_side_reset_n, .frame_locked, .sof_detect, .start_of_frame_n,
    .req_valid, .req_kind, .req_addr, .req_wdata, .req_ready, .rsp_done,
    .rsp_rdata, .upper_addr_port, .addr_latch_strobe,
    .addr_data_low_in(bus), .addr_data_low_out, .addr_data_low_oe,
    .program_fetch_strobe_n, .data_read_strobe_n, .write_strobe_n);
  ext_mem_model u_mem (
    .core_clk, .upper_addr_port, .addr_latch_strobe, .bus,
    .program_fetch_strobe_n, .data_read_strobe_n, .write_strobe_n, .drive);
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  task automatic bus_cycle(logic [1:0] kind, logic [15:0] a);
    int n, lows;
    logic [7:0] wd;
    logic [2:0] s;
    wait_ready();
    wd = $random(seed);
    @(posedge core_clk);
    req_valid <= 1;
    req_kind <= kind;
    req_addr <= a;
    req_wdata <= wd;
    @(posedge core_clk);
    req_valid <= 0;
    #1;
    chk("ale", 1, addr_latch_strobe);
    chk("upper", a[15:8], upper_addr_port);
    chk("low", {1'b1, a[7:0]},
      {addr_data_low_oe, addr_data_low_out});
    n = 0;
    lows = 0;
    while (rsp_done !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
      s = {write_strobe_n, data_read_strobe_n, program_fetch_strobe_n};
      if (s === ~(3'b001 << kind)) lows++;
      else chk("strobes", 3'b111, s);
    end
    chk("strobe len", SLEN, lows);
    chk("done", 1, rsp_done);
    if (kind == KIND_WRITE) exp_mem[a] = wd;
    else if (exp_mem.exists(a))
      chk("rdata", exp_mem[a], rsp_rdata);
    else chk("rdata", a[7:0] ^ a[15:8] ^ 8'h5a, rsp_rdata);
  endtask
  initial begin
    #40000;
    bad_count++;
    $display("Error watchdog expected end seen hang");
    complete_run();
  end
  initial begin
    logic [15:0] a;
    logic [2:0] v, p;
    int lows;
    repeat (8) @(posedge core_clk);
    #1;
    chk("reset pins", 16'hf1ff, {data_led_n, isolated_power_ctl_n,
      modem_side_reset_n, start_of_frame_n, addr_data_low_oe,
      addr_latch_strobe, full_speed_sel, write_strobe_n,
      upper_addr_port});
    @(posedge core_clk);
    rst_b <= 1;
    p = 0;
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk);
      v = $random(seed);
      led_on <= v[0];
      iso_power_on <= v[1];
      modem_side_reset_on <= v[2];
      #1;
      chk("data_led_n", !p[0], data_led_n);
      chk("iso_power_n", !p[1], isolated_power_ctl_n);
      chk("modem_reset_n", !p[2], modem_side_reset_n);
      p = v;
    end
    $display("Test indicators done");
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      for (int j = 0; j < 3; j++) bus_cycle(2 - j, a);
    end
    $display("Test bus cycles done");
    for (int j = 0; j < 2; j++) begin
      @(posedge core_clk);
      frame_locked <= j[0];
      sof_detect <= 1;
      @(posedge core_clk);
      sof_detect <= 0;
      lows = 0;
      repeat (14) begin
        #1;
        lows += !start_of_frame_n;
        @(posedge core_clk);
      end
      chk("sof len", j * SOF_STATES, lows);
    end
    $display("Test frame pulse done");
    for (int j = 0; j < 2; j++) begin
      @(posedge core_clk);
      idle_req <= 1;
      powerdown_req <= j[0];
      led_on <= 1;
      iso_power_on <= 1;
      modem_side_reset_on <= 1;
      @(posedge core_clk);
      idle_req <= 0;
      powerdown_req <= 0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("mode", j ? MODE_PDOWN : MODE_IDLE, power_mode);
      chk("ready", 0, req_ready);
      @(posedge core_clk);
      rst_pin <= 1;
      repeat (8) @(posedge core_clk);
      #1;
      chk("mode", MODE_RUN, power_mode);
      chk("forced", 16'h07ff, {data_led_n, isolated_power_ctl_n,
        modem_side_reset_n, upper_addr_port});
      chk("strap", j, full_speed_sel);
      repeat (64) @(posedge core_clk);
      #1;
      chk("strap", 1, full_speed_sel);
      @(posedge core_clk);
      rst_pin <= 0;
      a = $random(seed);
      bus_cycle(KIND_READ, a);
    end
    $display("Test low power and reset pin done");
    complete_run();
  end
endmodule
